/* agc_ctrl.sv */
`timescale 1ns/100ps
// Function
// R1: The cell noise flag reads 1 when signal power is under the threshold; the code holds it at 0 while the loop enable bit is 0.
// R2: One 3-bit threshold is shared; 000 and 001 both mean -30 dB.
// R3: Codes 101 to 111 (-70 to -90 dB) serve only the microphone loop.
// R4: Hysteresis codes give 1, 2 or 4 dB, and 11 turns hysteresis off.
// R5: The clip stepping bit enables stepping when 1 and resets to 0.
// R6: The 3-bit target code picks the cell loop output level.
// R7: Time code low bits pick attack, high bits decay, 0000 decays in 10 ms.
// R8: Attack and decay timing do not depend on the converter sample rate.
// R9: The enable bit hands the cell input gain to the loop.
// R10: The mic gain ceiling caps gain in 0.5 dB steps and resets to 7F.
// R11: The mic loop waits the enter debounce before silence mode.
// R12: The mic loop waits the leave debounce before normal mode.
// R13: Reserved bits read as zero and writes to them are dropped.
// R14: Leave debounce codes 100 to 111 give 4, 8, 16 and 32 ms.
module agc_ctrl (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [15:0] cell_power_db,
  input wire logic [15:0] mic_power_db,
  output logic [3:0] cell_threshold_db,
  output logic [3:0] mic_threshold_db,
  output logic cell_below_noise_flag,
  output logic [2:0] cell_hysteresis_db,
  output logic cell_clip_step_enable,
  output logic [7:0] cell_target_tenth_db,
  output logic [15:0] cell_attack_ms,
  output logic [15:0] cell_decay_ms,
  output logic cell_attack_tick,
  output logic cell_gain_by_loop,
  output logic [6:0] mic_gain_ceiling,
  output logic mic_silent
);
  agc_pkg::agc_cell_cfg_t cell_r;
  agc_pkg::agc_cell_cfg_t cell_nxt;
  agc_pkg::agc_mic_cfg_t mic_r;
  agc_pkg::agc_mic_cfg_t mic_nxt;
  logic ack_r;
  logic ack_nxt;
  logic [31:0] dat_r;
  logic [31:0] dat_nxt;
  logic nf_r;
  logic nf_nxt;
  logic [15:0] cell_rd;
  logic [15:0] mic_rd;
  logic req;
  logic wr_lo;
  logic wr_hi;
  logic [15:0] wd;
  logic half_ms_tick;
  logic mic_below;
  logic [15:0] gap_r;
  logic [15:0] gap_nxt;

  assign req = wb_cyc_i && wb_stb_i && !ack_r;
  assign wr_lo = req && wb_we_i && wb_sel_i[0];
  assign wr_hi = req && wb_we_i && wb_sel_i[1];
  assign wd = wb_dat_i[15:0];

  // Power bits 15:4 and threshold are both attenuation magnitudes in tens of dB.
  // The shared code maps 000 and 001 onto 3 (30 dB).
  assign mic_threshold_db = (cell_r.noise_floor_level <= 3'h1) ? 4'h3 :
    4'(cell_r.noise_floor_level) + 4'h2; // see R2
  // The cell loop cannot go below 60 dB; extended codes clamp there.
  assign cell_threshold_db = (cell_r.noise_floor_level > 3'h4) ? 4'h6 :
    mic_threshold_db; // see R3

  // Readback assembles fields; reserved bit positions stay zero.
  always_comb begin
    cell_rd = 16'h0000;
    cell_rd[agc_pkg::CELL_NF_BIT] = nf_r; // see R1
    cell_rd[agc_pkg::NL_LSB +: 3] = cell_r.noise_floor_level;
    cell_rd[agc_pkg::HYS_LSB +: 2] = cell_r.cell_hysteresis_sel;
    cell_rd[agc_pkg::CLIP_BIT] = cell_r.cell_clip_step_enable;
    cell_rd[agc_pkg::TG_LSB +: 3] = cell_r.cell_target_level;
    cell_rd[agc_pkg::TC_LSB +: 4] = cell_r.cell_attack_decay_sel;
    cell_rd[agc_pkg::EN_BIT] = cell_r.cell_loop_enable;
    mic_rd = 16'h0000; // see R13
    mic_rd[agc_pkg::CEIL_LSB +: 7] = mic_r.mic_gain_ceiling;
    mic_rd[agc_pkg::DBNS_LSB +: 3] = mic_r.mic_enter_silence_debounce;
    mic_rd[agc_pkg::DBSN_LSB +: 3] = mic_r.mic_leave_silence_debounce;
  end

  // Byte lanes update only the bits that they carry; reserved ones drop.
  always_comb begin
    logic [15:0] nc;
    logic [15:0] nm;
    nc = cell_rd;
    nm = mic_rd;
    if (wb_adr_i == agc_pkg::CELL_CTRL_ADDR) begin
      if (wr_lo) nc[7:0] = wd[7:0];
      if (wr_hi) nc[15:8] = wd[15:8];
    end
    if (wb_adr_i == agc_pkg::MIC_CTRL_ADDR) begin
      if (wr_lo) nm[7:0] = wd[7:0];
      if (wr_hi) nm[15:8] = wd[15:8];
    end
    cell_nxt.noise_floor_level = nc[agc_pkg::NL_LSB +: 3];
    cell_nxt.cell_hysteresis_sel = nc[agc_pkg::HYS_LSB +: 2];
    cell_nxt.cell_clip_step_enable = nc[agc_pkg::CLIP_BIT]; // see R5
    cell_nxt.cell_target_level = nc[agc_pkg::TG_LSB +: 3];
    cell_nxt.cell_attack_decay_sel = nc[agc_pkg::TC_LSB +: 4];
    cell_nxt.cell_loop_enable = nc[agc_pkg::EN_BIT];
    mic_nxt.mic_gain_ceiling = nm[agc_pkg::CEIL_LSB +: 7]; // see R10
    mic_nxt.mic_enter_silence_debounce = nm[agc_pkg::DBNS_LSB +: 3];
    mic_nxt.mic_leave_silence_debounce = nm[agc_pkg::DBSN_LSB +: 3];
  end

  // Bus answer one cycle after the request; unmapped addresses read zero.
  always_comb begin
    ack_nxt = req;
    dat_nxt = dat_r;
    if (req && !wb_we_i) begin
      if (wb_adr_i == agc_pkg::CELL_CTRL_ADDR) begin
        dat_nxt = {16'h0000, cell_rd};
      end else if (wb_adr_i == agc_pkg::MIC_CTRL_ADDR) begin
        dat_nxt = {16'h0000, mic_rd};
      end else begin
        dat_nxt = 32'h0000_0000;
      end
    end
  end

  // The flag is forced low while the loop is off, since it means nothing.
  always_comb begin
    nf_nxt = cell_r.cell_loop_enable &&
      (cell_power_db[15:4] > 12'(cell_threshold_db)); // see R1
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cell_r <= '0;
      mic_r <= '{agc_pkg::CEIL_RST, 3'h0, 3'h0};
    end else begin
      cell_r <= cell_nxt;
      mic_r <= mic_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ack_r <= 1'b0;
      dat_r <= 32'h0000_0000;
    end else begin
      ack_r <= ack_nxt;
      dat_r <= dat_nxt;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      nf_r <= 1'b0;
    end else begin
      nf_r <= nf_nxt;
    end
  end

  assign wb_ack_o = ack_r;
  assign wb_dat_o = dat_r;

  always_comb begin
    case (cell_r.cell_hysteresis_sel)
      2'b00: cell_hysteresis_db = 3'h1;
      2'b01: cell_hysteresis_db = 3'h2;
      2'b10: cell_hysteresis_db = 3'h4;
      default: cell_hysteresis_db = 3'h0; // see R4
    endcase
  end

  always_comb begin
    case (cell_r.cell_target_level)
      3'h0: cell_target_tenth_db = 8'h37;
      3'h1: cell_target_tenth_db = 8'h50;
      3'h2: cell_target_tenth_db = 8'h64;
      3'h3: cell_target_tenth_db = 8'h78;
      3'h4: cell_target_tenth_db = 8'h8C;
      3'h5: cell_target_tenth_db = 8'hAA;
      3'h6: cell_target_tenth_db = 8'hC8;
      default: cell_target_tenth_db = 8'hF0; // see R6
    endcase
  end

  assign cell_attack_ms =
    agc_pkg::ATTACK_MS[cell_r.cell_attack_decay_sel[1:0]]; // see R7
  assign cell_decay_ms = (cell_r.cell_attack_decay_sel == 4'h0) ?
    agc_pkg::DECAY_ZERO_MS :
    agc_pkg::DECAY_MS[cell_r.cell_attack_decay_sel[3:2]]; // see R7
  assign cell_clip_step_enable = cell_r.cell_clip_step_enable;
  assign cell_gain_by_loop = cell_r.cell_loop_enable; // see R9
  assign cell_below_noise_flag = nf_r;
  assign mic_gain_ceiling = mic_r.mic_gain_ceiling; // see R10

  // Time base comes from the system clock, never from the sample rate.
  agc_tick #(
    .DIV(agc_pkg::HALF_MS_CYC)
  ) u_half_ms (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(half_ms_tick)
  ); // see R8
  agc_tick #(
    .DIV(agc_pkg::MS_CYC)
  ) u_ms (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(cell_attack_tick)
  ); // see R8

  assign mic_below = mic_power_db[15:4] > 12'(mic_threshold_db);
  agc_debounce u_mic_db (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .tick(half_ms_tick),
    .below(mic_below),
    .enter_code(mic_r.mic_enter_silence_debounce),
    .leave_code(mic_r.mic_leave_silence_debounce),
    .silent(mic_silent)
  ); // see R11 see R12

  // Cycles since the last millisecond tick; only the checks below read it.
  always_comb begin
    gap_nxt = cell_attack_tick ? 16'h0000 : gap_r + 16'h0001;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gap_r <= 16'h0000;
    end else begin
      gap_r <= gap_nxt;
    end
  end

  // A read is taken on one edge and answered on the next.
  sequence s_read_taken;
    req && !wb_we_i;
  endsequence
  sequence s_cell_read_taken;
    s_read_taken ##0 wb_adr_i == agc_pkg::CELL_CTRL_ADDR;
  endsequence
  sequence s_mic_read_taken;
    s_read_taken ##0 wb_adr_i == agc_pkg::MIC_CTRL_ADDR;
  endsequence

  a_flag_follows: assert property ( // see R1
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.cell_loop_enable && cell_power_db[15:4] > 12'(cell_threshold_db)
    |=> cell_below_noise_flag)
    else $error("Noise flag missed a quiet input.");
  a_flag_off: assert property ( // see R1
    @(posedge ref_clk) disable iff (!resetn)
    !cell_r.cell_loop_enable |=> !cell_below_noise_flag)
    else $error("Noise flag set while loop off.");
  a_thresh_low: assert property ( // see R2
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.noise_floor_level <= 3'h1 |-> mic_threshold_db == 4'h3)
    else $error("Low threshold codes not 30 dB.");
  a_thresh_ext: assert property ( // see R3
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.noise_floor_level > 3'h4 |-> cell_threshold_db == 4'h6 &&
    mic_threshold_db > 4'h6)
    else $error("Extended threshold codes wrong.");
  a_hys_off: assert property ( // see R4
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.cell_hysteresis_sel == 2'b11 |-> cell_hysteresis_db == 3'h0)
    else $error("Hysteresis not off.");
  a_clip_write: assert property ( // see R5
    @(posedge ref_clk) disable iff (!resetn)
    wr_hi && wb_adr_i == agc_pkg::CELL_CTRL_ADDR
    |=> cell_clip_step_enable == $past(wd[agc_pkg::CLIP_BIT]))
    else $error("Clip stepping bit write lost.");
  a_target_ends: assert property ( // see R6
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.cell_target_level == 3'h7 |-> cell_target_tenth_db == 8'hF0)
    else $error("Deepest target level wrong.");
  a_decay_zero: assert property ( // see R7
    @(posedge ref_clk) disable iff (!resetn)
    cell_r.cell_attack_decay_sel == 4'h0 |-> cell_decay_ms == 16'h000A &&
    cell_attack_ms == 16'h0008)
    else $error("Code zero timing wrong.");
  a_tick_space: assert property ( // see R8
    @(posedge ref_clk) disable iff (!resetn)
    cell_attack_tick == (gap_r == 16'(agc_pkg::MS_CYC - 1)))
    else $error("Millisecond tick spacing wrong.");
  a_write_enable: assert property ( // see R9
    @(posedge ref_clk) disable iff (!resetn)
    wr_lo && wb_adr_i == agc_pkg::CELL_CTRL_ADDR
    |=> cell_gain_by_loop == $past(wd[0]))
    else $error("Enable bit write lost.");
  a_ceiling_write: assert property ( // see R10
    @(posedge ref_clk) disable iff (!resetn)
    wr_hi && wb_adr_i == agc_pkg::MIC_CTRL_ADDR
    |=> mic_gain_ceiling == $past(wd[agc_pkg::CEIL_LSB +: 7]))
    else $error("Gain ceiling write lost.");
  a_read_answer: assert property ( // see R13
    @(posedge ref_clk) disable iff (!resetn)
    s_read_taken |=> wb_ack_o && wb_dat_o[31:16] == 16'h0000)
    else $error("Read answer late or upper half nonzero.");
  a_resv_zero: assert property ( // see R13
    @(posedge ref_clk) disable iff (!resetn)
    s_cell_read_taken |=> wb_dat_o[15] == 1'b0)
    else $error("Reserved bits read nonzero.");
  a_mic_resv: assert property ( // see R13
    @(posedge ref_clk) disable iff (!resetn)
    s_mic_read_taken |=> wb_dat_o[2:0] == 3'h0)
    else $error("Mic reserved bits read nonzero.");
  a_ack_one: assert property (
    @(posedge ref_clk) disable iff (!resetn)
    wb_ack_o |=> !wb_ack_o)
    else $error("Ack held too long.");
endmodule

/* agc_pkg.sv */
package agc_pkg;
  // Register byte addresses are the register index times four.
  localparam logic [7:0] CELL_CTRL_IDX = 8'h24;
  localparam logic [7:0] MIC_CTRL_IDX = 8'h26;
  localparam logic [9:0] CELL_CTRL_ADDR = {CELL_CTRL_IDX, 2'b00};
  localparam logic [9:0] MIC_CTRL_ADDR = {MIC_CTRL_IDX, 2'b00};
  // Cell control field positions.
  localparam int CELL_NF_BIT = 14;
  localparam int NL_LSB = 11;
  localparam int HYS_LSB = 9;
  localparam int CLIP_BIT = 8;
  localparam int TG_LSB = 5;
  localparam int TC_LSB = 1;
  localparam int EN_BIT = 0;
  // Mic control field positions.
  localparam int CEIL_LSB = 9;
  localparam int DBNS_LSB = 6;
  localparam int DBSN_LSB = 3;
  // Reset values.
  localparam logic [6:0] CEIL_RST = 7'h7F;
  // Timing.
  localparam int CLK_HZ = 20000000;
  localparam int HALF_MS_US = 500;
  localparam int HALF_MS_CYC = CLK_HZ / 1000000 * HALF_MS_US;
  localparam int MS_CYC = CLK_HZ / 1000;
  localparam logic [15:0] ATTACK_MS [4] = '{16'h0008, 16'h000B,
    16'h0010, 16'h0014};
  localparam logic [15:0] DECAY_MS [4] = '{16'h0064, 16'h00C8,
    16'h0190, 16'h01F4};
  localparam logic [15:0] DECAY_ZERO_MS = 16'h000A;

  typedef struct packed {
    logic [2:0] noise_floor_level;
    logic [1:0] cell_hysteresis_sel;
    logic cell_clip_step_enable;
    logic [2:0] cell_target_level;
    logic [3:0] cell_attack_decay_sel;
    logic cell_loop_enable;
  } agc_cell_cfg_t;

  typedef struct packed {
    logic [6:0] mic_gain_ceiling;
    logic [2:0] mic_enter_silence_debounce;
    logic [2:0] mic_leave_silence_debounce;
  } agc_mic_cfg_t;

  typedef enum logic [1:0] {
    AGC_NORMAL = 2'b00,
    AGC_TO_SIL = 2'b01,
    AGC_SILENT = 2'b10,
    AGC_TO_NRM = 2'b11
  } agc_mode_t;
endpackage

/* agc_tick.sv */
`timescale 1ns/100ps
// Divides the system clock to a fixed tick; timing stays sample-rate free.
module agc_tick #(
  parameter int DIV = 10000
) (
  input wire logic ref_clk,
  input wire logic resetn,
  output logic tick
);
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  always_comb begin
    cnt_nxt = (cnt_r == 16'(DIV - 1)) ? 16'h0000 : cnt_r + 16'h0001;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 16'h0000;
    end else begin
      cnt_r <= cnt_nxt;
    end
  end
  assign tick = (cnt_r == 16'(DIV - 1));
endmodule

/* agc_debounce.sv */
`timescale 1ns/100ps
// Silence-mode tracker for the microphone loop, counting half-ms ticks.
module agc_debounce (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic tick,
  input wire logic below,
  input wire logic [2:0] enter_code,
  input wire logic [2:0] leave_code,
  output logic silent
);
  agc_pkg::agc_mode_t st_r;
  agc_pkg::agc_mode_t st_nxt;
  logic [6:0] cnt_r;
  logic [6:0] cnt_nxt;
  logic [6:0] enter_len;
  logic [6:0] leave_len;
  // Code 0 is zero time, code n is 2^(n-1) half-ms ticks.
  assign enter_len = (enter_code == 3'h0) ? 7'h00 :
    7'(7'h01 << (enter_code - 3'h1)); // see R11
  assign leave_len = (leave_code == 3'h0) ? 7'h00 :
    7'(7'h01 << (leave_code - 3'h1)); // see R12 see R14
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    case (st_r)
      agc_pkg::AGC_NORMAL: begin
        cnt_nxt = 7'h00;
        if (below) begin
          st_nxt = (enter_len == 7'h00) ? agc_pkg::AGC_SILENT :
            agc_pkg::AGC_TO_SIL;
        end
      end
      agc_pkg::AGC_TO_SIL: begin
        if (!below) begin
          st_nxt = agc_pkg::AGC_NORMAL;
        end else if (tick) begin
          cnt_nxt = cnt_r + 7'h01;
          if (cnt_r + 7'h01 >= enter_len) begin
            st_nxt = agc_pkg::AGC_SILENT; // see R11
          end
        end
      end
      agc_pkg::AGC_SILENT: begin
        cnt_nxt = 7'h00;
        if (!below) begin
          st_nxt = (leave_len == 7'h00) ? agc_pkg::AGC_NORMAL :
            agc_pkg::AGC_TO_NRM;
        end
      end
      agc_pkg::AGC_TO_NRM: begin
        if (below) begin
          st_nxt = agc_pkg::AGC_SILENT;
        end else if (tick) begin
          cnt_nxt = cnt_r + 7'h01;
          if (cnt_r + 7'h01 >= leave_len) begin
            st_nxt = agc_pkg::AGC_NORMAL; // see R12
          end
        end
      end
      default: begin
        st_nxt = agc_pkg::AGC_NORMAL;
        cnt_nxt = 7'h00;
      end
    endcase
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= agc_pkg::AGC_NORMAL;
      cnt_r <= 7'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  assign silent = (st_r == agc_pkg::AGC_SILENT) ||
    (st_r == agc_pkg::AGC_TO_NRM);

  // The code may be rewritten while counting, so the check looks back.
  sequence s_quiet_started;
    st_r == agc_pkg::AGC_NORMAL ##1 st_r == agc_pkg::AGC_TO_SIL;
  endsequence

  a_enter_zero: assert property ( // see R11
    @(posedge ref_clk) disable iff (!resetn)
    st_r == agc_pkg::AGC_NORMAL && below && enter_code == 3'h0
    |=> silent)
    else $error("Zero debounce did not enter silence.");
  a_leave_zero: assert property ( // see R12
    @(posedge ref_clk) disable iff (!resetn)
    st_r == agc_pkg::AGC_SILENT && !below && leave_code == 3'h0
    |=> !silent)
    else $error("Zero debounce did not leave silence.");
  a_enter_hold: assert property ( // see R11
    @(posedge ref_clk) disable iff (!resetn)
    s_quiet_started |-> $past(enter_code) != 3'h0)
    else $error("Debounce used with zero code.");
endmodule

/* agc_ctrl_bench.sv */
`timescale 1ns/100ps
module agc_ctrl_bench;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [9:0] wb_adr_i = 10'h000;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o;
  logic [15:0] cell_power_db = 16'h0000;
  logic [15:0] mic_power_db = 16'h0000;
  logic [3:0] cell_threshold_db;
  logic [3:0] mic_threshold_db;
  logic cell_below_noise_flag;
  logic [2:0] cell_hysteresis_db;
  logic cell_clip_step_enable;
  logic [7:0] cell_target_tenth_db;
  logic [15:0] cell_attack_ms;
  logic [15:0] cell_decay_ms;
  logic cell_attack_tick;
  logic cell_gain_by_loop;
  logic [6:0] mic_gain_ceiling;
  logic mic_silent;
  int error_cnt = 0;
  int checks = 0;
  int n;
  logic [3:0] c;
  logic [15:0] v;
  // Expected decodes, one entry per field code.
  localparam logic [3:0] THR_C [8] = '{4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h6,
    4'h6, 4'h6};
  localparam logic [3:0] THR_M [8] = '{4'h3, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7,
    4'h8, 4'h9};
  localparam logic [2:0] HYS [4] = '{3'h1, 3'h2, 3'h4, 3'h0};
  localparam logic [7:0] TGT [8] = '{8'h37, 8'h50, 8'h64, 8'h78, 8'h8C,
    8'hAA, 8'hC8, 8'hF0};
  localparam logic [15:0] ATT [4] = '{16'h0008, 16'h000B, 16'h0010,
    16'h0014};
  localparam logic [15:0] DEC [4] = '{16'h0064, 16'h00C8, 16'h0190,
    16'h01F4};

  agc_ctrl i_agc_ctrl (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i),
    .wb_sel_i(wb_sel_i),
    .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o),
    .cell_power_db(cell_power_db),
    .mic_power_db(mic_power_db),
    .cell_threshold_db(cell_threshold_db),
    .mic_threshold_db(mic_threshold_db),
    .cell_below_noise_flag(cell_below_noise_flag),
    .cell_hysteresis_db(cell_hysteresis_db),
    .cell_clip_step_enable(cell_clip_step_enable),
    .cell_target_tenth_db(cell_target_tenth_db),
    .cell_attack_ms(cell_attack_ms),
    .cell_decay_ms(cell_decay_ms),
    .cell_attack_tick(cell_attack_tick),
    .cell_gain_by_loop(cell_gain_by_loop),
    .mic_gain_ceiling(mic_gain_ceiling),
    .mic_silent(mic_silent)
  );

  always #25 ref_clk = ~ref_clk;

  task finish_test;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Holds the request until ack is seen; a slave that never answers
  // is reported rather than left hanging.
  task wb_xfer(input logic w, input logic [9:0] a, input logic [15:0] d,
      output logic [15:0] q);
    int k;
    k = 0;
    @(posedge ref_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= 4'h3;
    do begin
      @(posedge ref_clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) chk(wb_ack_o, 1'b1);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask

  task wr(input logic [9:0] a, input logic [15:0] d);
    logic [15:0] q;
    wb_xfer(1'b1, a, d, q);
  endtask

  task rd(input logic [9:0] a, input logic [15:0] e);
    logic [15:0] q;
    wb_xfer(1'b0, a, 16'h0000, q);
    chk(q, e);
  endtask

  task wait_silent(input logic lvl, input int lim);
    n = 0;
    while (mic_silent !== lvl && n < lim) begin
      @(posedge ref_clk);
      n++;
    end
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h0000);
    rd(agc_pkg::MIC_CTRL_ADDR, 16'hFE00);
    chk(mic_gain_ceiling, 7'h7F);
    chk(cell_clip_step_enable, 1'b0);
    for (int i = 0; i < 16; i++) begin
      c = i[3:0];
      v = {2'b00, c[2:0], c[1:0], c[1], c[2:0], c, c[0]};
      wr(agc_pkg::CELL_CTRL_ADDR, v);
      repeat (2) @(posedge ref_clk);
      chk(cell_threshold_db, THR_C[c[2:0]]);
      chk(mic_threshold_db, THR_M[c[2:0]]);
      chk(cell_hysteresis_db, HYS[c[1:0]]);
      chk(cell_clip_step_enable, c[1]);
      chk(cell_target_tenth_db, TGT[c[2:0]]);
      chk(cell_attack_ms, ATT[c[1:0]]);
      chk(cell_decay_ms, c == 4'h0 ? 16'h000A : DEC[c[3:2]]);
      chk(cell_gain_by_loop, c[0]);
      rd(agc_pkg::CELL_CTRL_ADDR, v);
    end
    // Reserved and read-only bits, then an unmapped place.
    wr(agc_pkg::CELL_CTRL_ADDR, 16'h7FFF);
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h3FFF);
    wr(agc_pkg::MIC_CTRL_ADDR, 16'hFFF8);
    rd(agc_pkg::MIC_CTRL_ADDR, 16'hFFF8);
    wr(10'h094, 16'h1234);
    rd(10'h094, 16'h0000);
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h3FFF);
    wr(agc_pkg::MIC_CTRL_ADDR, 16'h0A08);
    rd(agc_pkg::MIC_CTRL_ADDR, 16'h0A08);
    chk(mic_gain_ceiling, 7'h05);
    // Threshold 40 dB with the cell loop on; the flag tracks the input.
    wr(agc_pkg::CELL_CTRL_ADDR, 16'h1001);
    cell_power_db <= 16'h0050;
    repeat (3) @(posedge ref_clk);
    chk(cell_below_noise_flag, 1'b1);
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h5001);
    cell_power_db <= 16'h0030;
    repeat (3) @(posedge ref_clk);
    chk(cell_below_noise_flag, 1'b0);
    cell_power_db <= 16'h0050;
    wr(agc_pkg::CELL_CTRL_ADDR, 16'h1000);
    repeat (3) @(posedge ref_clk);
    chk(cell_below_noise_flag, 1'b0);
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h1000);
    // Zero enter debounce, then a one half-ms leave debounce.
    mic_power_db <= 16'h0050;
    repeat (3) @(posedge ref_clk);
    chk(mic_silent, 1'b1);
    mic_power_db <= 16'h0000;
    wait_silent(1'b0, 10010);
    chk(mic_silent, 1'b0);
    // A 1 ms enter debounce needs at least one whole tick of quiet.
    wr(agc_pkg::MIC_CTRL_ADDR, 16'h0A88);
    mic_power_db <= 16'h0050;
    repeat (8000) @(posedge ref_clk);
    chk(mic_silent, 1'b0);
    wait_silent(1'b1, 12100);
    chk(mic_silent, 1'b1);
    // Attack pacing comes from the system clock alone.
    wr(agc_pkg::CELL_CTRL_ADDR, 16'h1001);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cell_attack_tick !== 1'b1 && n < 20010);
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (cell_attack_tick !== 1'b1 && n < 20010);
    chk(n, 20000);
    // Reset in mid-run restores every field.
    resetn <= 1'b0;
    repeat (2) @(posedge ref_clk);
    chk(mic_gain_ceiling, 7'h7F);
    chk(cell_gain_by_loop, 1'b0);
    chk(mic_silent, 1'b0);
    resetn <= 1'b1;
    rd(agc_pkg::CELL_CTRL_ADDR, 16'h0000);
    rd(agc_pkg::MIC_CTRL_ADDR, 16'hFE00);
    finish_test();
  end

  // The tests take about 60000 cycles; this leaves a clear margin.
  initial begin
    repeat (100000) @(posedge ref_clk);
    error_cnt++;
    $display("mismatch at %0t: watchdog expired", $time);
    finish_test();
  end
endmodule
